//--- isi_pkg.sv
// Package for the interrupt source identity register bank.
// Assumes a plain address/strobe register port with byte addresses.
package isi_pkg;

    localparam int          ISI_LINES      = 6;
    localparam int          ISI_AW         = 8;
    localparam int          ISI_DW         = 32;
    localparam int          ISI_SYNC_DEPTH = 3;

    // Identity register offsets (byte addresses from the block base)
    localparam logic [7:0]  ISI_COMPARATOR_LINE_OFF = 8'h64;
    localparam logic [7:0]  ISI_DMA_LINE_OFF        = 8'h68;
    localparam logic [7:0]  ISI_AUDIO_SERIAL_OFF    = 8'h6c;
    localparam logic [7:0]  ISI_TOUCH_SENSE_OFF     = 8'h70;
    localparam logic [7:0]  ISI_CONVERTER_LINE_OFF  = 8'h74;
    localparam logic [7:0]  ISI_CLOCK_LINE_OFF      = 8'h7c;

    // Event status / mask registers
    localparam logic [7:0]  ISI_EVT_STATUS_OFF      = 8'h90;
    localparam logic [7:0]  ISI_EVT_MASK_OFF        = 8'h94;

    // Field layout
    localparam int          ISI_SRC_FIELD_MSB = 2;
    localparam int          ISI_SRC_BIT       = 0;
    localparam logic [5:0]  ISI_MASK_RST      = 6'h00;
    localparam logic [5:0]  ISI_STATUS_RST    = 6'h00;
    localparam logic [31:0] ISI_UNMAPPED_RD   = 32'h0000_0000;

    // Line order inside every six-bit vector
    localparam logic [7:0]  ISI_OFFSETS [ISI_LINES] = '{
        ISI_COMPARATOR_LINE_OFF, ISI_DMA_LINE_OFF, ISI_AUDIO_SERIAL_OFF,
        ISI_TOUCH_SENSE_OFF, ISI_CONVERTER_LINE_OFF, ISI_CLOCK_LINE_OFF
    };

endpackage : isi_pkg

//--- isi_source_regs.sv
// Interrupt source identity register bank for six peripheral lines.
// Assumes asynchronous peripheral interrupt levels and a one-cycle read port.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps

// Summary of operation
// - Offset 0x64, line 25: bit 0 shows the temperature alarm interrupt.
// - Offset 0x68, line 26: bit 0 shows the peripheral DMA interrupt.
// - Offset 0x6c, line 27: bit 0 shows the audio serial interrupt.
// - Offset 0x70, line 28: bit 0 shows the touch sensing interrupt.
// - Offset 0x74, line 29: bit 0 shows the converter interrupt.
// - Offset 0x7c, line 31: bit 0 shows the real-time clock interrupt.
// - Source field is bits 2..0; bits 2 and 1 always read zero.
// - Identity contents follow live interrupt levels; reset clears them to zero.
// - Identity registers are read-only; bits 31..3 read zero.
module isi_source_regs
    import isi_pkg::*;
(
    input  wire logic                      ref_clk_in,          // System clock, 50 MHz
    input  wire logic                      sys_rst_in,          // Synchronous reset, high
    input  wire logic                      temperature_alarm_irq_in, // Line 25 source
    input  wire logic                      peripheral_dma_irq_in,    // Line 26 source
    input  wire logic                      audio_serial_irq_in,      // Line 27 source
    input  wire logic                      touch_sense_irq_in,       // Line 28 source
    input  wire logic                      converter_irq_in,         // Line 29 source
    input  wire logic                      clock_irq_in,             // Line 31 source
    input  wire logic [isi_pkg::ISI_AW-1:0] reg_addr_in,        // Byte address
    input  wire logic [isi_pkg::ISI_DW-1:0] reg_wdata_in,       // Write data
    input  wire logic                      reg_wr_in,           // Write strobe
    input  wire logic                      reg_rd_in,           // Read strobe
    output logic      [isi_pkg::ISI_DW-1:0] reg_rdata_out,      // Read data, next cycle
    output logic                           irq_out              // Unmasked event pending
);

    //--------------------------------------------------------------
    // Input synchronisers
    //--------------------------------------------------------------
    logic [ISI_LINES-1:0] raw_irq;
    logic [ISI_LINES-1:0] sync1_q;
    logic [ISI_LINES-1:0] sync2_q;
    logic [ISI_LINES-1:0] sync3_q;
    logic [ISI_LINES-1:0] live_q;
    logic [ISI_LINES-1:0] live_d;

    assign raw_irq = {clock_irq_in, converter_irq_in, touch_sense_irq_in,
                      audio_serial_irq_in, peripheral_dma_irq_in,
                      temperature_alarm_irq_in};

    always_ff @(posedge ref_clk_in) begin
        sync1_q <= raw_irq;
        sync2_q <= sync1_q;
        sync3_q <= sync2_q;
    end

    // Level changes once the second and third stages agree
    genvar gi;
    generate
        for (gi = 0; gi < ISI_LINES; gi++) begin : g_filt
            assign live_d[gi] = (sync2_q[gi] == sync3_q[gi]) ? sync3_q[gi] : live_q[gi];
        end
    endgenerate

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            live_q <= '0;
        end else begin
            live_q <= live_d;
        end
    end

    //--------------------------------------------------------------
    // Event status and mask
    //--------------------------------------------------------------
    logic [ISI_LINES-1:0] status_q;
    logic [ISI_LINES-1:0] mask_q;
    logic [ISI_LINES-1:0] rise;
    logic                 wr_status;
    logic                 wr_mask;

    assign rise      = live_d & ~live_q;
    assign wr_status = reg_wr_in && (reg_addr_in == ISI_EVT_STATUS_OFF);
    assign wr_mask   = reg_wr_in && (reg_addr_in == ISI_EVT_MASK_OFF);

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            status_q <= ISI_STATUS_RST;
        end else begin
            status_q <= (status_q & ~(wr_status ? reg_wdata_in[ISI_LINES-1:0] : '0)) | rise;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            mask_q <= ISI_MASK_RST;
        end else if (wr_mask) begin
            mask_q <= reg_wdata_in[ISI_LINES-1:0];
        end
    end

    assign irq_out = |(status_q & mask_q);

    //--------------------------------------------------------------
    // Read port
    //--------------------------------------------------------------
    logic [ISI_DW-1:0] rdata_d;

    // Identity writes match no write decode and are dropped
    always_comb begin
        rdata_d = ISI_UNMAPPED_RD;
        for (int i = 0; i < ISI_LINES; i++) begin
            if (reg_addr_in == ISI_OFFSETS[i]) begin
                rdata_d = {{(ISI_DW-ISI_SRC_FIELD_MSB-1){1'b0}}, 2'b00, live_q[i]};
            end
        end
        if (reg_addr_in == ISI_EVT_STATUS_OFF) begin
            rdata_d = {{(ISI_DW-ISI_LINES){1'b0}}, status_q};
        end
        if (reg_addr_in == ISI_EVT_MASK_OFF) begin
            rdata_d = {{(ISI_DW-ISI_LINES){1'b0}}, mask_q};
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= '0;
        end else if (reg_rd_in) begin
            reg_rdata_out <= rdata_d;
        end else begin
            reg_rdata_out <= '0;
        end
    end

    //--------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------
    upper_bits_zero_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        $past(reg_rd_in) |-> reg_rdata_out[ISI_DW-1:1] == '0 || $past(reg_addr_in) >= ISI_EVT_STATUS_OFF)
        else $error("Identity read returned nonzero upper bits");

    dma_id_read_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        reg_rd_in && reg_addr_in == ISI_DMA_LINE_OFF |=> reg_rdata_out == {31'h0, $past(live_q[1])})
        else $error("Dma identity read mismatch");

    alarm_id_read_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        reg_rd_in && reg_addr_in == ISI_COMPARATOR_LINE_OFF |=> reg_rdata_out[0] == $past(live_q[0]))
        else $error("Alarm identity read mismatch");

    audio_id_read_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        reg_rd_in && reg_addr_in == ISI_AUDIO_SERIAL_OFF |=> reg_rdata_out[0] == $past(live_q[2]))
        else $error("Audio identity read mismatch");

    touch_id_read_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        reg_rd_in && reg_addr_in == ISI_TOUCH_SENSE_OFF |=> reg_rdata_out[0] == $past(live_q[3]))
        else $error("Touch identity read mismatch");

    conv_id_read_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        reg_rd_in && reg_addr_in == ISI_CONVERTER_LINE_OFF |=> reg_rdata_out[0] == $past(live_q[4]))
        else $error("Converter identity read mismatch");

    rtc_id_read_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        reg_rd_in && reg_addr_in == ISI_CLOCK_LINE_OFF |=> reg_rdata_out[0] == $past(live_q[5]))
        else $error("Clock identity read mismatch");

    field_high_zero_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        $past(reg_rd_in) && $past(reg_addr_in) < ISI_EVT_STATUS_OFF |-> reg_rdata_out[2:1] == 2'b00)
        else $error("Source field high bits not zero");

    write_ignored_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        reg_wr_in && reg_addr_in < ISI_EVT_STATUS_OFF |=> mask_q == $past(mask_q))
        else $error("Identity write changed state");

    sync_follow_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        (sync2_q[0] == sync3_q[0]) |=> live_q[0] == $past(sync3_q[0]))
        else $error("Live level did not follow synchroniser");

    //--------------------------------------------------------------
    // Assertions on reset, events, the read port and the synchronisers
    //--------------------------------------------------------------
    // Reset must leave no stale event or read word behind
    reset_clear_a: assert property (@(posedge ref_clk_in)
        sys_rst_in |=> status_q == '0 && mask_q == '0 && live_q == '0 && reg_rdata_out == '0)
        else $error("Reset did not clear state");

    rdata_idle_zero_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        !reg_rd_in |=> reg_rdata_out == '0)
        else $error("Read data present without a read");

    status_write_ignored_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        reg_wr_in && reg_addr_in < ISI_EVT_STATUS_OFF |=> status_q == ($past(status_q) | $past(rise)))
        else $error("Identity write changed event status");

    // A rising live level must always land in the status register
    status_set_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        (|rise) |=> (status_q & $past(rise)) == $past(rise))
        else $error("Live rise did not set status");

    status_clear_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        wr_status && rise == '0 |=> (status_q & $past(reg_wdata_in[ISI_LINES-1:0])) == '0)
        else $error("Write one did not clear status");

    mask_write_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        wr_mask |=> mask_q == $past(reg_wdata_in[ISI_LINES-1:0]))
        else $error("Mask write not taken");

    irq_level_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        (status_q & mask_q) != '0 |-> irq_out)
        else $error("Unmasked event without interrupt");

    clock_sync_follow_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        (sync2_q[5] == sync3_q[5]) |=> live_q[5] == $past(sync3_q[5]))
        else $error("Clock line live level did not follow synchroniser");

    live_hold_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        (sync2_q != sync3_q) && $past(sync2_q == sync3_q) |=> live_q == $past(live_q))
        else $error("Live level moved before stages agreed");

endmodule : isi_source_regs

//--- isi_src_model.sv
// Model of the six peripheral interrupt sources.
// Assumes the bench requests a level vector; lines move just after a clock edge.
`timescale 1ns/1ps
module isi_src_model (
    input  wire logic       clk_in,  // System clock
    input  wire logic [5:0] lvl_in,  // Requested levels
    output logic      [5:0] irq_out  // Peripheral interrupt lines
);
    initial irq_out = 6'h00;
    always @(posedge clk_in) begin
        irq_out <= lvl_in;
    end
endmodule : isi_src_model

//--- isi_source_regs_tb_top.sv
// Self-checking bench for the source identity register bank.
// Assumes read data one cycle after the read strobe and a 50 MHz clock.
`timescale 1ns/1ps
module isi_source_regs_tb_top;
    import isi_pkg::*;
    logic        ref_clk_in, sys_rst_in, reg_wr_in, reg_rd_in, irq_out;
    logic [7:0]  reg_addr_in;
    logic [31:0] reg_wdata_in, reg_rdata_out, rnd, d;
    logic [5:0]  lvl, irqs, v;
    int          n_fail, samples_checked, cyc;

    isi_src_model u_src (.clk_in(ref_clk_in), .lvl_in(lvl), .irq_out(irqs));
    isi_source_regs u_dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
        .temperature_alarm_irq_in(irqs[0]), .peripheral_dma_irq_in(irqs[1]),
        .audio_serial_irq_in(irqs[2]), .touch_sense_irq_in(irqs[3]),
        .converter_irq_in(irqs[4]), .clock_irq_in(irqs[5]), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .irq_out(irq_out));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    function automatic logic [31:0] exp_id(input logic [5:0] l, input int i);
        return {31'h0, l[i]};
    endfunction : exp_id
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] val);
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= val;
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b0;
        #1 q = reg_rdata_out;
    endtask : rd
    task automatic set_lvl(input logic [5:0] l);
        @(posedge ref_clk_in);
        lvl <= l;
        repeat (6) @(posedge ref_clk_in);
    endtask : set_lvl
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report

    initial begin
        ref_clk_in = 1'b0;
        forever #10 ref_clk_in = ~ref_clk_in;
    end
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            final_report();
        end
    end

    initial begin
        {reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in, lvl} = '0;
        rnd = 32'd43491;
        sys_rst_in = 1'b1;
        repeat (12) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        // ------------------------------------------------------------
        // Identity bits track live levels; writes leave them alone
        // ------------------------------------------------------------
        for (int k = 0; k < 24; k++) begin
            rnd = xs(rnd);
            set_lvl(k == 0 ? 6'h3f : (k == 1 ? 6'h00 : rnd[5:0]));
            for (int i = 0; i < ISI_LINES; i++) begin
                wr(ISI_OFFSETS[i], xs(rnd + i));
                rd(ISI_OFFSETS[i], d);
                chk(d, exp_id(lvl, i), "ident");
            end
        end
        rd(8'h00, d);
        chk(d, 32'h0, "unmapped");
        $display("test ident done");
        // ------------------------------------------------------------
        // Event status, mask and interrupt output
        // ------------------------------------------------------------
        set_lvl(6'h00);
        wr(ISI_EVT_STATUS_OFF, 32'h3f);
        rnd = xs(rnd);
        v = rnd[5:0] | 6'h01;
        set_lvl(v);
        rd(ISI_EVT_STATUS_OFF, d);
        chk(d, {26'h0, v}, "status");
        chk({31'h0, irq_out}, 32'h0, "masked");
        wr(ISI_EVT_MASK_OFF, {26'h0, v});
        #1 chk({31'h0, irq_out}, 32'h1, "unmasked");
        wr(ISI_EVT_STATUS_OFF, {26'h0, v});
        #1 chk({31'h0, irq_out}, 32'h0, "cleared");
        rd(ISI_EVT_MASK_OFF, d);
        chk(d, {26'h0, v}, "mask");
        $display("test irq done");
        // ------------------------------------------------------------
        // Reset in mid-run with all lines high
        // ------------------------------------------------------------
        set_lvl(6'h3f);
        @(posedge ref_clk_in);
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        rd(ISI_EVT_MASK_OFF, d);
        chk(d, 32'h0, "rst mask");
        chk({31'h0, irq_out}, 32'h0, "rst irq");
        rd(ISI_CLOCK_LINE_OFF, d);
        chk(d, 32'h1, "rst ident");
        rd(ISI_EVT_STATUS_OFF, d);
        chk(d, 32'h3f, "rst status");
        $display("test reset done");
        final_report();
    end
endmodule : isi_source_regs_tb_top
